// ---- core/fbk_seq.sv ----
// Purpose: mode sequencing, mask, foldback and converter control
// Assumes: pins and analog comparator outputs are asynchronous
// Notes: long times are parameters so simulation can shorten them
//
// Contract
// - torch starts: standby, armed, pin high
// - pin fall ends torch, clears arm
// - strobe during torch goes straight to flash
// - torch ended first means no flash
// - finished flash returns standby, clears arm
// - mask cuts flash current, mode kept
// - mask during flash sets its flag
// - mask release ramps current back gradually
// - both masks high use first level
// - foldback enabled halves switching rate
// - low battery uses reduced flash level
// - limit code 00/01/10, 11 reserved
// - dc limit: hold, flag, rewrite flash level
// - converter measures forward, die, external
// - idle-armed write defers to active exit
// - armed write converts at once
// - forward code 01, result after 1 ms
// - flash forward sample just before timeout
// - code 10 converts die temperature
// - external only with pin two analog
// - 5 V mode: regulate, disconnect source
// - mode selector 00/01/10/11 encodings
// - pin one function 00/01/10 encodings
`timescale 1ns/100ps
`default_nettype none
module fbk_seq
   import fbk_pkg::*;
#(
   parameter int CONV_CYCLES = CONV_CYC,
   parameter int FLASH_STEP_CYCLES = FLASH_STEP_CYC
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire fbk_cfg_t cfg,
   input wire logic mode_wr,
   input wire logic [1:0] mode_wr_data,
   input wire logic arm_wr,
   input wire logic arm_wr_data,
   input wire logic fl_wr,
   input wire logic [3:0] fl_wr_data,
   input wire logic conv_wr,
   input wire logic [1:0] conv_wr_data,
   input wire logic flag_clr,
   input wire logic torch_mask_pin,
   input wire logic strobe_pin,
   input wire logic pa_mask_two,
   input wire logic battery_below,
   input wire logic vin_near_boost_output,
   input wire logic dc_limit_hit,
   input wire logic [3:0] adc_sample,
   output fbk_mode_t mode_selector_q,
   output logic drive_arm_q,
   output logic [3:0] flash_current_level_q,
   output fbk_flags_t flags_q,
   output logic [3:0] led_current_q,
   output logic led_source_en_q,
   output logic boost_5v_q,
   output logic switch_rate_half_q,
   output logic [1:0] current_limit_code_q,
   output logic indicator_drive_q,
   output logic [1:0] conv_mux_q,
   output logic [7:0] conversion_result_q
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_TORCH, ST_ASSIST, ST_FLASH, ST_VOUT5
   } fbk_state_t;
   fbk_state_t state_q;
   logic [9:0] s1_q, s2_q;
   logic torch_q, strobe_q, strobe_prev_q, mask2_q, lowbat_q, near_q, dcl_q;
   logic [3:0] sample_q;
   logic torch_in, strobe_rise, mask1_act, mask2_act, timeout, pre_timeout;
   logic active, exit_now, hold_q, pend_q, vf_flash_q, conv_start;
   logic [3:0] target, ramp_level;
   logic [7:0] tick_q;
   logic [31:0] step_cnt_q;
   logic [3:0] step_idx_q;
   logic ramp_tick;
   // ==========================================================
   // pin synchronisers
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_q <= 10'h000;
         s2_q <= 10'h000;
         strobe_prev_q <= 1'b0;
      end else begin
         s1_q <= {adc_sample, dc_limit_hit, vin_near_boost_output, battery_below,
                  pa_mask_two, strobe_pin, torch_mask_pin};
         s2_q <= s1_q;
         strobe_prev_q <= strobe_q;
      end
   end
   assign torch_q = s2_q[0];
   assign strobe_q = s2_q[1];
   assign mask2_q = s2_q[2];
   assign lowbat_q = s2_q[3];
   assign near_q = s2_q[4];
   assign dcl_q = s2_q[5];
   assign sample_q = s2_q[9:6];
   assign strobe_rise = strobe_q && !strobe_prev_q;
   assign torch_in = (cfg.pin_one_function == PIN1_TORCH) && torch_q;
   assign mask1_act = (cfg.pin_one_function == PIN1_MASK) && torch_q;
   assign mask2_act = (cfg.pin_two_function == PIN2_MASK) && mask2_q;
   assign active = (state_q != ST_IDLE);
   // ==========================================================
   // flash timer
   assign timeout = (state_q == ST_FLASH) && step_idx_q == cfg.flash_duration
                    && step_cnt_q == 32'(FLASH_STEP_CYCLES - 1);
   assign pre_timeout = (state_q == ST_FLASH)
                        && step_idx_q == cfg.flash_duration
                        && step_cnt_q == 32'(FLASH_STEP_CYCLES - 2);
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         step_cnt_q <= 32'h0000_0000;
         step_idx_q <= 4'h0;
      end else if (state_q != ST_FLASH) begin
         step_cnt_q <= 32'h0000_0000;
         step_idx_q <= 4'h0;
      end else if (step_cnt_q == 32'(FLASH_STEP_CYCLES - 1)) begin
         step_cnt_q <= 32'h0000_0000;
         step_idx_q <= step_idx_q + 4'h1;
      end else begin
         step_cnt_q <= step_cnt_q + 32'h0000_0001;
      end
   end
   // ==========================================================
   // mode state machine
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (drive_arm_q && mode_selector_q == MODE_STANDBY
                   && torch_in) begin
                  state_q <= ST_TORCH;
               end else if (drive_arm_q && mode_selector_q == MODE_ASSIST) begin
                  state_q <= ST_ASSIST;
               // from idle, flash only from armed flash mode
               end else if (drive_arm_q && mode_selector_q == MODE_FLASH
                            && strobe_rise) begin
                  state_q <= ST_FLASH;
               end else if (drive_arm_q && mode_selector_q == MODE_VOUT5) begin
                  state_q <= ST_VOUT5;
               end
            end
            ST_TORCH: begin
               if (strobe_rise && drive_arm_q) begin
                  state_q <= ST_FLASH;
               end else if (!torch_in || !drive_arm_q) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_FLASH: begin
               if (timeout || !drive_arm_q) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_ASSIST: begin
               if (!drive_arm_q || mode_selector_q != MODE_ASSIST) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_VOUT5: begin
               if (!drive_arm_q || mode_selector_q != MODE_VOUT5) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
   assign exit_now = active && !(state_q == ST_TORCH && strobe_rise)
                     && ((state_q == ST_TORCH && !torch_in) || timeout
                     || !drive_arm_q
                     || (state_q == ST_ASSIST && mode_selector_q != MODE_ASSIST)
                     || (state_q == ST_VOUT5 && mode_selector_q != MODE_VOUT5));
   // ==========================================================
   // arm bit and mode selector
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         drive_arm_q <= 1'b0;
      // device clears arm on pin fall
      end else if (state_q == ST_TORCH && !torch_in && !strobe_rise) begin
         drive_arm_q <= 1'b0;
      end else if (timeout) begin
         drive_arm_q <= 1'b0;
      end else if (arm_wr) begin
         drive_arm_q <= arm_wr_data;
      end
   end
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_selector_q <= MODE_STANDBY;
      end else if (timeout) begin
         mode_selector_q <= MODE_STANDBY;
      end else if (mode_wr) begin
         mode_selector_q <= fbk_mode_t'(mode_wr_data);
      end
   end
   // ==========================================================
   // current target and ramp
   always_comb begin
      target = LEVEL_ZERO;
      case (state_q)
         ST_TORCH, ST_ASSIST: target = cfg.torch_current_level;
         ST_FLASH: begin
            if (mask1_act) begin
               target = cfg.mask_one_level;
            end else if (mask2_act) begin
               target = cfg.mask_two_level;
            end else if (cfg.low_battery_threshold != LOWBAT_OFF
                         && lowbat_q) begin
               target = cfg.reduced_level;
            end else begin
               target = flash_current_level_q;
            end
         end
         default: target = LEVEL_ZERO;
      endcase
   end
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         tick_q <= 8'h00;
      end else if (ramp_tick) begin
         tick_q <= 8'h00;
      end else begin
         tick_q <= tick_q + 8'h01;
      end
   end
   assign ramp_tick = (tick_q == 8'(RAMP_TICK_CYC - 1));
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         hold_q <= 1'b0;
      end else if (state_q != ST_FLASH) begin
         hold_q <= 1'b0;
      end else if (dcl_q && ramp_level < target) begin
         hold_q <= 1'b1;
      end
   end
   // cut at once, step back up
   fbk_ramp u_ramp (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .enable(state_q == ST_TORCH || state_q == ST_ASSIST
              || state_q == ST_FLASH),
      .tick(ramp_tick),
      .hold(hold_q || (state_q == ST_FLASH && dcl_q)),
      .target(target),
      .level_q(ramp_level)
   );
   assign led_current_q = ramp_level;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         flash_current_level_q <= FL_LEVEL_RST;
      end else if (state_q == ST_FLASH && dcl_q && !hold_q
                   && ramp_level < target && !mask1_act && !mask2_act) begin
         flash_current_level_q <= ramp_level;
      end else if (fl_wr) begin
         flash_current_level_q <= fl_wr_data;
      end
   end
   // ==========================================================
   // flags, set wins over clear
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         flags_q <= '0;
      end else begin
         flags_q.mask_one_seen <= (state_q == ST_FLASH && mask1_act)
                                  || (flags_q.mask_one_seen && !flag_clr);
         flags_q.mask_two_seen <= (state_q == ST_FLASH && mask2_act)
                                  || (flags_q.mask_two_seen && !flag_clr);
         flags_q.dc_limit_seen <= (state_q == ST_FLASH && dcl_q)
                                  || (flags_q.dc_limit_seen && !flag_clr);
      end
   end
   // ==========================================================
   // analog controls
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         led_source_en_q <= 1'b0;
         boost_5v_q <= 1'b0;
         switch_rate_half_q <= 1'b0;
         current_limit_code_q <= ILIM_2A0;
         indicator_drive_q <= 1'b0;
      end else begin
         boost_5v_q <= (state_q == ST_VOUT5);
         led_source_en_q <= (state_q == ST_TORCH || state_q == ST_ASSIST
                             || state_q == ST_FLASH);
         switch_rate_half_q <= cfg.switch_rate_reduce_en && near_q && active;
         current_limit_code_q <= (cfg.battery_current_limit == ILIM_RSVD)
                                 ? ILIM_2A0 : cfg.battery_current_limit;
         indicator_drive_q <= cfg.indicator_en
                              && cfg.pin_two_function == PIN2_IND && !active;
      end
   end
   // ==========================================================
   // converter control
   logic sel_ok;
   // external only with analog pin two
   assign sel_ok = conv_wr_data != SEL_NONE
                   && (conv_wr_data != SEL_EXT
                       || cfg.pin_two_function == PIN2_ADC);
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pend_q <= 1'b0;
         vf_flash_q <= 1'b0;
      end else begin
         if (conv_wr && sel_ok && !(drive_arm_q && active)) begin
            pend_q <= 1'b1;
         end else if (exit_now) begin
            pend_q <= 1'b0;
         end
         if (conv_wr && sel_ok && drive_arm_q && state_q == ST_FLASH
             && conv_wr_data == SEL_VF) begin
            vf_flash_q <= 1'b1;
         end else if (state_q != ST_FLASH) begin
            vf_flash_q <= 1'b0;
         end
      end
   end
   logic [1:0] sel_q;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sel_q <= SEL_NONE;
      end else if (conv_wr && sel_ok && !(drive_arm_q && active)) begin
         sel_q <= conv_wr_data;
      end
   end
   assign conv_start = (conv_wr && sel_ok && drive_arm_q && active
                        && !(state_q == ST_FLASH && conv_wr_data == SEL_VF))
                       || (pend_q && exit_now);
   fbk_conv #(.CONV_CYCLES(CONV_CYCLES)) u_conv (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .start(conv_start),
      .snap(vf_flash_q && pre_timeout),
      .sel(conv_wr ? conv_wr_data : sel_q),
      .sample(sample_q),
      .mux_q(conv_mux_q),
      .busy_q(),
      .result_q(conversion_result_q)
   );
   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   torch_entry_a: assert property (
      state_q == ST_TORCH && $past(state_q) == ST_IDLE
      |-> $past(drive_arm_q && mode_selector_q == MODE_STANDBY && torch_in))
      else $error("torch entered without its conditions");
   torch_exit_a: assert property (
      state_q == ST_TORCH && !torch_in && !strobe_rise
      |=> state_q == ST_IDLE && !drive_arm_q)
      else $error("torch pin fall did not end torch");
   torch_flash_a: assert property (
      state_q == ST_TORCH && strobe_rise && drive_arm_q |=> state_q == ST_FLASH)
      else $error("strobe in torch did not reach flash");
   no_late_fire_a: assert property (
      state_q == ST_IDLE && mode_selector_q != MODE_FLASH
      |=> state_q != ST_FLASH)
      else $error("flash fired outside flash mode");
   flash_done_a: assert property (
      timeout |=> state_q == ST_IDLE && !drive_arm_q
                  && mode_selector_q == MODE_STANDBY)
      else $error("flash end did not return to standby");
   mask_cut_a: assert property (
      state_q == ST_FLASH && mask1_act && $stable(cfg) [*3]
      |-> led_current_q <= cfg.mask_one_level)
      else $error("mask did not cut the current");
   mask_flag_a: assert property (
      state_q == ST_FLASH && mask2_act |=> flags_q.mask_two_seen)
      else $error("mask flag not set");
   ramp_step_a: assert property (
      led_current_q > $past(led_current_q)
      |-> led_current_q == $past(led_current_q) + 4'h1)
      else $error("current rose by more than one step");
   limit_code_a: assert property (
      ##1 current_limit_code_q != ILIM_RSVD)
      else $error("reserved limit code driven");
   boost_output_iso_a: assert property (
      state_q == ST_VOUT5 |=> boost_5v_q && !led_source_en_q)
      else $error("5 V mode left the source connected");
   torch_c: cover property (state_q == ST_TORCH ##1 state_q == ST_FLASH);
   mask_c: cover property (state_q == ST_FLASH && mask1_act && mask2_act);
   defer_c: cover property (pend_q && exit_now);
endmodule : fbk_seq
`default_nettype wire

// ---- core/fbk_pkg.sv ----
// Purpose: shared constants and types for the flash LED mode sequencer
// Assumes: 20 MHz system clock
// Notes: level codes are 4-bit steps of the analog current DACs
package fbk_pkg;
   // ==========================================================
   // encodings
   typedef enum logic [1:0] {
      MODE_STANDBY, MODE_VOUT5, MODE_ASSIST, MODE_FLASH
   } fbk_mode_t;
   localparam logic [1:0] PIN1_HIZ = 2'h0;
   localparam logic [1:0] PIN1_TORCH = 2'h1;
   localparam logic [1:0] PIN1_MASK = 2'h2;
   localparam logic [1:0] PIN2_IND = 2'h1;
   localparam logic [1:0] PIN2_MASK = 2'h2;
   localparam logic [1:0] PIN2_ADC = 2'h3;
   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam logic [1:0] SEL_VF = 2'h1;
   localparam logic [1:0] SEL_TEMP = 2'h2;
   localparam logic [1:0] SEL_EXT = 2'h3;
   localparam logic [1:0] ILIM_1A5 = 2'h0;
   localparam logic [1:0] ILIM_1A75 = 2'h1;
   localparam logic [1:0] ILIM_2A0 = 2'h2;
   localparam logic [1:0] ILIM_RSVD = 2'h3;
   localparam logic [2:0] LOWBAT_OFF = 3'h0;
   localparam logic [3:0] LEVEL_ZERO = 4'h0;
   localparam logic [3:0] FL_LEVEL_RST = 4'h0;
   localparam logic [7:0] RESULT_RST = 8'h00;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int MASK_CUT_NS = 21000;
   localparam int MASK_CUT_CYC = MASK_CUT_NS / CLK_PERIOD_NS;
   localparam int CONV_TIME_US = 1000;
   localparam int CONV_CYC = CONV_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int FLASH_STEP_MS = 100;
   localparam int FLASH_STEP_CYC = FLASH_STEP_MS * 1000000 / CLK_PERIOD_NS;
   localparam int RAMP_TICK_CYC = 20;
   // ==========================================================
   // carriers
   typedef struct packed {
      logic [3:0] torch_current_level;
      logic [3:0] mask_one_level;
      logic [3:0] mask_two_level;
      logic [3:0] reduced_level;
      logic [3:0] flash_duration;
      logic [1:0] pin_one_function;
      logic [1:0] pin_two_function;
      logic [2:0] low_battery_threshold;
      logic [1:0] battery_current_limit;
      logic switch_rate_reduce_en;
      logic indicator_en;
   } fbk_cfg_t;
   typedef struct packed {
      logic mask_one_seen;
      logic mask_two_seen;
      logic dc_limit_seen;
   } fbk_flags_t;
endpackage : fbk_pkg

// ---- core/fbk_ramp.sv ----
// Purpose: LED current level with instant cut and stepped rise
// Assumes: tick is a one-cycle enable
// Notes: hold freezes any rise
`timescale 1ns/100ps
`default_nettype none
module fbk_ramp
   import fbk_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic enable,
   input wire logic tick,
   input wire logic hold,
   input wire logic [3:0] target,
   output logic [3:0] level_q
);
   // ==========================================================
   // level
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         level_q <= LEVEL_ZERO;
      end else if (!enable) begin
         level_q <= LEVEL_ZERO;
      end else if (target < level_q) begin
         level_q <= target;
      end else if (tick && !hold && level_q < target) begin
         level_q <= level_q + 4'h1;
      end
   end
endmodule : fbk_ramp
`default_nettype wire

// ---- core/fbk_conv.sv ----
// Purpose: 4-bit converter sequencing and result register
// Assumes: sample is already synchronised
// Notes: snap captures at once, start waits the conversion time
`timescale 1ns/100ps
`default_nettype none
module fbk_conv
   import fbk_pkg::*;
#(
   parameter int CONV_CYCLES = CONV_CYC
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic start,
   input wire logic snap,
   input wire logic [1:0] sel,
   input wire logic [3:0] sample,
   output logic [1:0] mux_q,
   output logic busy_q,
   output logic [7:0] result_q
);
   logic [15:0] cnt_q;
   // ==========================================================
   // sequencing
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= 16'h0000;
         busy_q <= 1'b0;
         mux_q <= SEL_NONE;
      end else if (start) begin
         cnt_q <= 16'(CONV_CYCLES - 1);
         busy_q <= 1'b1;
         mux_q <= sel;
      end else if (busy_q) begin
         cnt_q <= cnt_q - 16'h0001;
         busy_q <= (cnt_q != 16'h0000);
      end
   end
   // ==========================================================
   // result, sample in bits 5:2
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         result_q <= RESULT_RST;
      end else if (snap || (busy_q && cnt_q == 16'h0000)) begin
         result_q <= {2'h0, sample, 2'h0};
      end
   end
endmodule : fbk_conv
`default_nettype wire

// ---- sim/fbk_sensor.sv ----
// Purpose: image sensor and torch switch model for the sequencer
// Assumes: requests come from the bench at the falling edge
// Notes: pins follow requests at the next rising edge
`timescale 1ns/100ps
`default_nettype none
module fbk_sensor (
   input wire logic sys_clk,
   input wire logic torch_req,
   input wire logic strobe_req,
   output var logic torch_mask_pin,
   output var logic strobe_pin
);
   initial torch_mask_pin = 1'b0;
   initial strobe_pin = 1'b0;
   always @(posedge sys_clk) begin
      torch_mask_pin <= torch_req;
      strobe_pin <= strobe_req;
   end
endmodule : fbk_sensor
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for the flash mode sequencer
// Assumes: shortened conversion and flash step counts
// Notes: inputs change at the falling edge
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import fbk_pkg::*;
   logic sys_clk = 0, reset_n = 0, torch_req = 0, strobe_req = 0;
   logic mode_wr = 0, arm_wr = 0, arm_wr_data = 0, fl_wr = 0, conv_wr = 0;
   logic flag_clr = 0, pa_mask_two = 0, battery_below = 0;
   logic vin_near_boost_output = 0, dc_limit_hit = 0;
   logic [1:0] mode_wr_data = 0, conv_wr_data = 0;
   logic [3:0] fl_wr_data = 0, adc_sample = 0;
   fbk_cfg_t cfg = '0;
   wire torch_mask_pin, strobe_pin;
   fbk_mode_t mode_selector_q;
   fbk_flags_t flags_q;
   logic drive_arm_q, led_source_en_q, boost_5v_q, switch_rate_half_q;
   logic indicator_drive_q;
   logic [3:0] flash_current_level_q, led_current_q;
   logic [1:0] current_limit_code_q, conv_mux_q;
   logic [7:0] conversion_result_q;
   int n_mismatch = 0, n_tests = 0;
   always #25 sys_clk = ~sys_clk;
   fbk_sensor u_fbk_sensor (.sys_clk, .torch_req, .strobe_req,
      .torch_mask_pin, .strobe_pin);
   fbk_seq #(.CONV_CYCLES(8), .FLASH_STEP_CYCLES(16)) u_fbk_seq (
      .sys_clk, .reset_n, .cfg, .mode_wr, .mode_wr_data, .arm_wr,
      .arm_wr_data, .fl_wr, .fl_wr_data, .conv_wr, .conv_wr_data,
      .flag_clr, .torch_mask_pin, .strobe_pin, .pa_mask_two,
      .battery_below, .vin_near_boost_output, .dc_limit_hit, .adc_sample,
      .mode_selector_q, .drive_arm_q, .flash_current_level_q, .flags_q,
      .led_current_q, .led_source_en_q, .boost_5v_q, .switch_rate_half_q,
      .current_limit_code_q, .indicator_drive_q, .conv_mux_q,
      .conversion_result_q);
   // ==========================================================
   // helpers
   task results;
      $display("mismatches %0d tests %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : tick
   task automatic wait_sig(ref logic s, input logic v);
      int i;
      for (i = 0; i < 60 && s !== v; i++) tick(1);
      if (s !== v) begin
         n_mismatch++;
         results();
      end
   endtask : wait_sig
   task write_arm(input logic v);
      arm_wr = 1;
      arm_wr_data = v;
      tick(1);
      arm_wr = 0;
   endtask : write_arm
   task write_mode(input logic [1:0] m);
      mode_wr = 1;
      mode_wr_data = m;
      tick(1);
      mode_wr = 0;
   endtask : write_mode
   task conv(input logic [1:0] c);
      conv_wr = 1;
      conv_wr_data = c;
      tick(1);
      conv_wr = 0;
   endtask : conv
   // ==========================================================
   // scenarios
   task t_torch;
      write_arm(1);
      torch_req = 1;
      wait_sig(led_source_en_q, 1'b1);
      chk("torch mode", 8'(MODE_STANDBY), 8'(mode_selector_q));
      tick(70);
      chk("torch level", 8'h03, 8'(led_current_q));
      torch_req = 0;
      wait_sig(drive_arm_q, 1'b0);
      wait_sig(led_source_en_q, 1'b0);
   endtask : t_torch
   task t_handover;
      write_arm(1);
      torch_req = 1;
      wait_sig(led_source_en_q, 1'b1);
      strobe_req = 1;
      tick(6);
      torch_req = 0;
      tick(8);
      chk("flash arm", 8'h01, 8'(drive_arm_q));
      wait_sig(drive_arm_q, 1'b0);
      chk("after flash", 8'(MODE_STANDBY), 8'(mode_selector_q));
      strobe_req = 0;
      tick(4);
   endtask : t_handover
   task t_no_fire;
      write_arm(1);
      torch_req = 1;
      wait_sig(led_source_en_q, 1'b1);
      torch_req = 0;
      wait_sig(drive_arm_q, 1'b0);
      write_arm(1);
      strobe_req = 1;
      tick(10);
      chk("no flash", 8'h00, 8'(led_source_en_q));
      strobe_req = 0;
      write_arm(0);
   endtask : t_no_fire
   task t_mask;
      cfg.pin_one_function = PIN1_MASK;
      cfg.pin_two_function = PIN2_MASK;
      cfg.mask_one_level = 4'h2;
      cfg.mask_two_level = 4'h1;
      cfg.flash_duration = 4'h7;
      fl_wr = 1;
      fl_wr_data = 4'h4;
      write_mode(2'h3);
      fl_wr = 0;
      write_arm(1);
      strobe_req = 1;
      tick(89);
      chk("flash level", 8'h04, 8'(led_current_q));
      torch_req = 1;
      tick(1);
      pa_mask_two = 1;
      tick(4);
      chk("both masks", 8'h02, 8'(led_current_q));
      chk("mask flag", 8'h01, 8'(flags_q.mask_two_seen));
      chk("mask one flag", 8'h01, 8'(flags_q.mask_one_seen));
      chk("mask mode", 8'(MODE_FLASH), 8'(mode_selector_q));
      pa_mask_two = 0;
      torch_req = 0;
      tick(5);
      chk("mask ramp", 8'h00, 8'(led_current_q == 4'h4));
      wait_sig(drive_arm_q, 1'b0);
      strobe_req = 0;
   endtask : t_mask
   task t_dc;
      cfg.low_battery_threshold = 3'h1;
      cfg.reduced_level = 4'h2;
      battery_below = 1;
      write_mode(2'h3);
      write_arm(1);
      strobe_req = 1;
      tick(60);
      chk("low battery", 8'h02, 8'(led_current_q));
      battery_below = 0;
      dc_limit_hit = 1;
      tick(10);
      chk("dc flag", 8'h01, 8'(flags_q.dc_limit_seen));
      chk("dc level", 8'h02, 8'(flash_current_level_q));
      tick(40);
      chk("dc hold", 8'h02, 8'(led_current_q));
      wait_sig(drive_arm_q, 1'b0);
      dc_limit_hit = 0;
      strobe_req = 0;
      cfg.low_battery_threshold = LOWBAT_OFF;
   endtask : t_dc
   task t_boost_output;
      cfg.indicator_en = 1;
      cfg.pin_two_function = PIN2_IND;
      cfg.switch_rate_reduce_en = 1;
      vin_near_boost_output = 1;
      tick(3);
      chk("indicator", 8'h01, 8'(indicator_drive_q));
      cfg.indicator_en = 0;
      write_mode(2'h1);
      write_arm(1);
      tick(4);
      chk("boost", 8'h01, 8'(boost_5v_q));
      chk("source", 8'h00, 8'(led_source_en_q));
      chk("foldback", 8'h01, 8'(switch_rate_half_q));
      write_arm(0);
      tick(3);
      chk("boost off", 8'h00, 8'(boost_5v_q));
   endtask : t_boost_output
   task t_conv;
      adc_sample = 4'h5;
      conv(2'h2);
      write_mode(2'h2);
      write_arm(1);
      tick(12);
      chk("deferred", 8'h00, conversion_result_q);
      conv(2'h1);
      tick(12);
      chk("vf mux", 8'h01, 8'(conv_mux_q));
      chk("vf result", 8'h14, conversion_result_q);
      conv(2'h3);
      tick(12);
      chk("ext refused", 8'h01, 8'(conv_mux_q));
      adc_sample = 4'hA;
      write_arm(0);
      tick(12);
      chk("temp mux", 8'h02, 8'(conv_mux_q));
      chk("temp result", 8'h28, conversion_result_q);
   endtask : t_conv
   task t_limit;
      for (int i = 0; i < 4; i++) begin
         cfg.battery_current_limit = 2'(i);
         tick(2);
         chk("limit", (i == 3) ? 8'h02 : 8'(i), 8'(current_limit_code_q));
      end
   endtask : t_limit
   initial begin
      cfg.pin_one_function = PIN1_TORCH;
      cfg.battery_current_limit = ILIM_2A0;
      cfg.torch_current_level = 4'h3;
      tick(3);
      reset_n = 1;
      chk("reset limit", 8'h02, 8'(current_limit_code_q));
      tick(3);
      t_torch();
      t_handover();
      t_no_fire();
      t_mask();
      t_dc();
      t_boost_output();
      t_conv();
      t_limit();
      results();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      results();
   end
endmodule : tb_top
`default_nettype wire
